// *** shared/ppdcc_pkg.sv ***
// Purpose: Shared constants and types for the single-port PSE control block
// Assumes: 250 MHz mclk; analog front end reports digitised outcomes
// Notes: Functional notes below are mirrored by tags in the design files
// Functional notes
// - Pick the maximum power level from the level resistor, sampled at reset release.
// - Latch midspan, legacy, twin and level inputs at reset exit; ignore later changes.
// - Reset at power-up or when the reset pin is low; port stays off.
// - Decode seven level codes: Type 1, Type 2, four extended, unrestricted.
// - Extended modes add 38.7W, 52.7W, 70W and 90W allocations.
// - Twin-signature PD with twin support enabled doubles inrush, cutoff and limit.
// - Type 1 mode never issues a second class event; class 4 acts as 0.
// - Unrestricted mode powers any valid PD with raised current limits.
// - Remove port power on a cutoff fault or a limit fault.
// - Detect disconnect of a powered PD and switch power off.
// - Report detection as one of eight outcomes from unknown to voltage out of range.
// - Move from detection to classification after a good signature.
// - Legacy mode accepts cap high, sig low, good, sig high; otherwise only good, plus sig low with twin support.
// - Legacy mode allocates 13W to class 0, 1, 2 or 3.
// - Twin support lets a signature-too-low outcome go on to classification.
// - Classify right after detection; each event drives about 18V for 12ms.
// - After a valid class, set cutoff and limit thresholds from the class.
// - Single-event class in all modes; class 0 to 3 grants allocation directly.
// - Class 0 is allocated like class 3.
// - Class 4 gets 13W demoted to class 0 in Type 1, 25.5W in Type 2.
// - Class 4 is powered after one event in Type 1 and unrestricted modes; else more events follow.
// - Midspan select high uses midspan detection timing, low uses endpoint timing.
// - Reset pin low pulses shorter than 4.5 us are filtered out.
package ppdcc_pkg;
  localparam int CLK_MHZ = 250;
  localparam int CLASS_TIME_MS = 12;
  localparam int CLASS_CYCLES = CLASS_TIME_MS * CLK_MHZ * 1000;
  localparam int CLASS_CNT_W = 22;
  localparam int RST_GLITCH_NS = 4500;
  localparam int RST_GLITCH_CYCLES = (RST_GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_CNT_W = 11;
  localparam int AXI_AW = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_CONFIG = 5'h08;
  localparam logic [4:0] OFS_EVENTS = 5'h0c;
  localparam logic CTRL_ENABLE_RESET = 1'h1;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int EV_CUT_BIT = 0;
  localparam int EV_LIM_BIT = 1;
  localparam int EV_DISC_BIT = 2;
  localparam int EV_REFUSE_BIT = 3;
  localparam int EV_W = 4;
  localparam logic [2:0] CLASS_MAX_STD = 3'h3;
  localparam logic [2:0] CLASS_FOUR = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    LVL_TYPE1, LVL_TYPE2, LVL_EXT38, LVL_EXT52, LVL_EXT70, LVL_EXT90, LVL_ULTRA
  } ppdcc_level_t;
  typedef enum logic [2:0] {
    DET_UNKNOWN, DET_SHORT, DET_CAP_HIGH, DET_SIG_LOW,
    DET_GOOD, DET_SIG_HIGH, DET_OPEN, DET_VOLT_RANGE
  } ppdcc_detect_t;
  typedef enum logic [3:0] {
    AL_NONE, AL_3W, AL_7W, AL_13W, AL_25W5, AL_38W7, AL_52W7, AL_70W, AL_90W, AL_ULTRA
  } ppdcc_alloc_t;
  typedef enum logic [2:0] {
    ST_HOLD, ST_DETECT, ST_CLASS, ST_EXTEND, ST_POWER, ST_IDLE
  } ppdcc_state_t;
endpackage

// *** shared/ppdcc_rst_if.sv ***
// Purpose: Carries the reset pin to its glitch filter and the held level back
// Assumes: Single clock domain
// Notes: No clock inside; the filter samples on mclk
`timescale 1ns/1ps
interface ppdcc_rst_if;
  logic pinLowN;
  logic hold;
  modport filt(input pinLowN, output hold);
  modport ctrl(output pinLowN, input hold);
endinterface

// *** src/ppdcc_rst_filter.sv ***
// Purpose: Glitch filter on the active-low reset pin
// Assumes: Pin is synchronous to mclk
// Notes: Hold is high from power-up until the pin is seen high
`timescale 1ns/1ps
module ppdcc_rst_filter
  import ppdcc_pkg::*;
(
  // Clock and power-on reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pin and filtered level
  ppdcc_rst_if.filt rif
);
  logic [RST_CNT_W-1:0] lowCnt_reg;
  logic hold_reg;
  wire lowLongEnough = (lowCnt_reg == RST_CNT_W'(RST_GLITCH_CYCLES - 1));

  // Short low pulses restart the count and never reach hold
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_reg <= '0;
      hold_reg <= 1'b1;
    end else if (rif.pinLowN) begin
      lowCnt_reg <= '0;
      hold_reg <= 1'b0;
    end else if (lowLongEnough) begin
      hold_reg <= 1'b1;
    end else begin
      lowCnt_reg <= lowCnt_reg + 1'b1;
    end
  end
  assign rif.hold = hold_reg;

  a_glitch_ignored: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(hold_reg) |-> $past(lowCnt_reg) == RST_CNT_W'(RST_GLITCH_CYCLES - 1))
    else $error("reset hold rose before the filter time");
endmodule

// *** src/ppdcc_top.sv ***
// Purpose: Autonomous single-port PSE detect, classify and power sequencer
// Assumes: Front end reports detection, class and fault results as digital levels
// Notes: Registers reachable over AXI4-Lite; configuration latched at reset exit
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module ppdcc_top
  import ppdcc_pkg::*;
#(
  parameter int CLASS_CYCLES_P = CLASS_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic resetPinN,
  // Configuration straps
  input wire logic [2:0] levelSelect,
  input wire logic midspanSelect,
  input wire logic legacyEnable,
  input wire logic twinSignatureEnable,
  // Detection front end
  output logic detectReq,
  input wire logic detectDone,
  input wire logic [2:0] detectOutcome,
  // Classification front end
  output logic classDrive,
  input wire logic [2:0] classResult,
  output logic extReq,
  input wire logic extDone,
  input wire logic extOk,
  input wire logic [2:0] extLevel,
  // Power path
  output logic portPower,
  input wire logic cutFault,
  input wire logic limFault,
  input wire logic disconnect,
  output logic [3:0] allocLevel,
  output logic [3:0] thresholdSelect,
  output logic currentDouble,
  output logic cutoffDisable,
  output logic midspanTiming,
  // AXI4-Lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Reset pin filter
  ppdcc_rst_if rif();
  assign rif.pinLowN = resetPinN;
  ppdcc_rst_filter uFilt (
    .mclk(mclk),
    .rst_n(rst_n),
    .rif(rif.filt)
  );
  wire pinHold = rif.hold;

  // Latched configuration
  logic cfgLatched_reg;
  ppdcc_level_t level_reg;
  logic midspan_reg;
  logic legacy_reg;
  logic twinEn_reg;
  wire ppdcc_level_t levelDecoded =
    (levelSelect > 3'(LVL_ULTRA)) ? LVL_TYPE1 : ppdcc_level_t'(levelSelect);

  // Captured once per reset exit, frozen until the next reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfgLatched_reg <= 1'b0;
      level_reg <= LVL_TYPE1;
      midspan_reg <= 1'b0;
      legacy_reg <= 1'b0;
      twinEn_reg <= 1'b0;
    end else if (pinHold) begin
      cfgLatched_reg <= 1'b0;
    end else if (!cfgLatched_reg) begin
      cfgLatched_reg <= 1'b1;
      level_reg <= levelDecoded;
      midspan_reg <= midspanSelect;
      legacy_reg <= legacyEnable;
      twinEn_reg <= twinSignatureEnable;
    end
  end
  assign midspanTiming = midspan_reg;

  // Sequencer state
  ppdcc_state_t st_reg;
  ppdcc_state_t st_next;
  logic [CLASS_CNT_W-1:0] classCnt_reg;
  ppdcc_detect_t outcome_reg;
  logic [2:0] class_reg;
  ppdcc_alloc_t alloc_reg;
  ppdcc_alloc_t alloc_next;
  logic twinPd_reg;
  logic portPower_reg;
  logic enable_reg;
  logic refuse;

  wire ppdcc_detect_t outcomeNow = ppdcc_detect_t'(detectOutcome);
  // Legacy widens the accepted set; twin support admits a low signature
  wire legacyOk = legacy_reg && (outcomeNow == DET_CAP_HIGH ||
    outcomeNow == DET_SIG_LOW || outcomeNow == DET_SIG_HIGH);
  wire twinOk = twinEn_reg && outcomeNow == DET_SIG_LOW;
  wire detectOk = outcomeNow == DET_GOOD || legacyOk || twinOk;
  wire classEnd = classCnt_reg == CLASS_CNT_W'(CLASS_CYCLES_P - 1);
  wire classValid = classResult <= CLASS_FOUR;
  wire isUltra = level_reg == LVL_ULTRA;
  wire isType1 = level_reg == LVL_TYPE1;
  wire goExtend = classValid && classResult == CLASS_FOUR && !isType1 && !isUltra;
  wire anyFault = cutFault || limFault;

  // One-event class outcome
  ppdcc_alloc_t classAlloc;
  always_comb begin
    classAlloc = AL_NONE;
    if (!classValid) begin
      classAlloc = AL_NONE;
    end else if (isUltra) begin
      classAlloc = AL_ULTRA;
    end else if (classResult == CLASS_FOUR) begin
      classAlloc = isType1 ? AL_13W : AL_NONE;
    end else if (legacy_reg || classResult == 3'h0 || classResult == CLASS_MAX_STD) begin
      classAlloc = AL_13W;
    end else if (classResult == 3'h1) begin
      classAlloc = AL_3W;
    end else begin
      classAlloc = AL_7W;
    end
  end

  // Extended grant; a Type 2 port demotes, wider ports refuse above their level
  wire extFits = extLevel <= 3'(level_reg) && extLevel != 3'(LVL_TYPE1)
    && extLevel != 3'(LVL_ULTRA);
  wire ppdcc_alloc_t extAlloc = !extOk ? AL_NONE :
    extFits ? ppdcc_alloc_t'(4'(extLevel) + 4'h3) :
    (level_reg == LVL_TYPE2) ? AL_25W5 : AL_NONE;

  always_comb begin
    st_next = st_reg;
    alloc_next = alloc_reg;
    refuse = 1'b0;
    case (st_reg)
      ST_HOLD: begin
        if (!pinHold) begin
          st_next = ST_DETECT;
        end
      end
      ST_DETECT: begin
        if (!enable_reg) begin
          st_next = ST_IDLE;
        end else if (cfgLatched_reg && detectDone) begin
          // Invalid outcomes stay here and simply retry
          st_next = detectOk ? ST_CLASS : ST_DETECT;
        end
      end
      ST_CLASS: begin
        if (!enable_reg) begin
          st_next = ST_IDLE;
        end else if (classEnd) begin
          alloc_next = classAlloc;
          if (goExtend) begin
            st_next = ST_EXTEND;
          end else if (classAlloc == AL_NONE) begin
            st_next = ST_DETECT;
            refuse = 1'b1;
          end else begin
            st_next = ST_POWER;
          end
        end
      end
      ST_EXTEND: begin
        if (!enable_reg) begin
          st_next = ST_IDLE;
        end else if (extDone) begin
          alloc_next = extAlloc;
          st_next = (extAlloc == AL_NONE) ? ST_DETECT : ST_POWER;
          refuse = extAlloc == AL_NONE;
        end
      end
      ST_POWER: begin
        // Faults and disconnect drop power at once
        if (!enable_reg) begin
          st_next = ST_IDLE;
        end else if (anyFault || disconnect) begin
          st_next = ST_DETECT;
        end
      end
      ST_IDLE: begin
        if (enable_reg) begin
          st_next = ST_DETECT;
        end
      end
      default: begin
        st_next = ST_HOLD;
      end
    endcase
    if (pinHold) begin
      st_next = ST_HOLD;
    end
  end

  // Port stays off for the whole reset hold
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_HOLD;
      portPower_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      portPower_reg <= st_next == ST_POWER;
    end
  end

  // Class event timer, about 12 ms of class drive
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      classCnt_reg <= '0;
    end else if (st_reg == ST_CLASS && !classEnd) begin
      classCnt_reg <= classCnt_reg + 1'b1;
    end else begin
      classCnt_reg <= '0;
    end
  end

  // Reported detection and class results
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      outcome_reg <= DET_UNKNOWN;
      class_reg <= '0;
      alloc_reg <= AL_NONE;
      twinPd_reg <= 1'b0;
    end else begin
      alloc_reg <= (st_next == ST_POWER || st_next == ST_EXTEND) ? alloc_next : AL_NONE;
      if (st_reg == ST_DETECT && detectDone) begin
        outcome_reg <= outcomeNow;
        twinPd_reg <= twinOk;
      end
      if (st_reg == ST_CLASS && classEnd) begin
        class_reg <= classResult;
      end
    end
  end

  assign detectReq = st_reg == ST_DETECT && cfgLatched_reg;
  assign classDrive = st_reg == ST_CLASS;
  assign extReq = st_reg == ST_EXTEND;
  assign portPower = portPower_reg;
  assign allocLevel = alloc_reg;
  // Thresholds follow the granted class; unrestricted mode has no cutoff
  assign thresholdSelect = portPower_reg ? alloc_reg : AL_NONE;
  assign cutoffDisable = portPower_reg && alloc_reg == AL_ULTRA;
  assign currentDouble = portPower_reg && twinPd_reg;

  // AXI4-Lite write path
  logic awHeld_reg;
  logic [AXI_AW-1:0] awAddr_reg;
  logic wHeld_reg;
  logic [31:0] wData_reg;
  logic wLane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic [EV_W-1:0] events_reg;

  assign s_axi_awready = !awHeld_reg && !bvalid_reg;
  assign s_axi_wready = !wHeld_reg && !bvalid_reg;
  wire doWrite = awHeld_reg && wHeld_reg;
  wire [AXI_AW-1:0] wWord = {awAddr_reg[AXI_AW-1:2], 2'b00};
  wire wMapped = wWord == OFS_CTRL || wWord == OFS_STATUS
    || wWord == OFS_CONFIG || wWord == OFS_EVENTS;
  wire ctrlWrite = doWrite && wLane0_reg && wWord == OFS_CTRL;
  wire evWrite = doWrite && wLane0_reg && wWord == OFS_EVENTS;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wHeld_reg <= 1'b0;
      wData_reg <= '0;
      wLane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wLane0_reg <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Enable gates the sequencer; clearing it turns the port off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= CTRL_ENABLE_RESET;
    end else if (ctrlWrite) begin
      enable_reg <= wData_reg[CTRL_ENABLE_BIT];
    end
  end

  // Sticky events, write one to clear; a new event in the clear cycle survives
  wire [EV_W-1:0] evSet = {refuse, portPower_reg && disconnect,
    portPower_reg && limFault, portPower_reg && cutFault};
  wire [EV_W-1:0] evClr = evWrite ? wData_reg[EV_W-1:0] : '0;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      events_reg <= '0;
    end else begin
      events_reg <= (events_reg & ~evClr) | evSet;
    end
  end

  // AXI4-Lite read path
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  wire [AXI_AW-1:0] rWord = {s_axi_araddr[AXI_AW-1:2], 2'b00};
  wire [31:0] statusWord = {18'h00000, alloc_reg, class_reg, outcome_reg,
    st_reg, portPower_reg};
  wire [31:0] configWord = {25'h0000000, cfgLatched_reg, twinEn_reg,
    legacy_reg, midspan_reg, level_reg};
  wire rMapped = rWord == OFS_CTRL || rWord == OFS_STATUS
    || rWord == OFS_CONFIG || rWord == OFS_EVENTS;
  wire [31:0] rdMux = (rWord == OFS_CTRL) ? {31'h00000000, enable_reg} :
    (rWord == OFS_STATUS) ? statusWord :
    (rWord == OFS_CONFIG) ? configWord :
    (rWord == OFS_EVENTS) ? {28'h0000000, events_reg} : 32'h00000000;
  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rdMux;
      rresp_reg <= rMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Checks
  a_hold_unpowered: assert property (
    pinHold |=> !portPower && st_reg == ST_HOLD)
    else $error("port powered during reset hold");
  a_config_frozen: assert property (
    cfgLatched_reg && !pinHold |=> $stable(level_reg) && $stable(legacy_reg)
      && $stable(twinEn_reg) && $stable(midspan_reg))
    else $error("latched configuration changed without reset");
  a_fault_off: assert property (
    portPower && anyFault && !pinHold |=> !portPower ##1 !portPower)
    else $error("port stayed powered after a fault");
  a_disconnect_off: assert property (
    portPower && disconnect |=> !portPower)
    else $error("port stayed powered after disconnect");
  a_class_length: assert property (
    $fell(classDrive) && $past(enable_reg) && !$past(pinHold)
      |-> $past(classCnt_reg) == CLASS_CNT_W'(CLASS_CYCLES_P - 1))
    else $error("class event ended early");
  a_type1_single: assert property (
    cfgLatched_reg && level_reg == LVL_TYPE1 |-> !extReq)
    else $error("second class event in Type 1 mode");
  a_invalid_retry: assert property (
    detectReq && detectDone && !detectOk && enable_reg && !pinHold
      |=> detectReq && !portPower)
    else $error("invalid detection did not repeat");
  a_good_classify: assert property (
    detectReq && detectDone && outcomeNow == DET_GOOD && enable_reg && !pinHold
      |=> classDrive [*2])
    else $error("good detection did not start classification");
  a_twin_double: assert property (
    currentDouble |-> twinEn_reg && outcome_reg == DET_SIG_LOW && portPower)
    else $error("current doubled without a twin PD");
endmodule

// *** tb/ppdcc_pd_model.sv ***
// Purpose: Behavioural powered device answering detection and class events
// Assumes: Signature, class and wanted level are set by the bench
// Notes: Idle answer lines carry inverted values so stale data differs from the last answer
`timescale 1ns/1ps
module ppdcc_pd_model (
  // Clock and sequencer requests
  input wire logic mclk,
  input wire logic detectReq,
  input wire logic classDrive,
  input wire logic extReq,
  // Scenario from the bench
  input wire logic [2:0] sigCode,
  input wire logic [2:0] classCode,
  input wire logic [2:0] levelWant,
  // Answers
  output logic detectDone,
  output logic [2:0] detectOutcome,
  output logic [2:0] classResult,
  output logic extDone,
  output logic extOk,
  output logic [2:0] extLevel
);
  logic [1:0] waitCnt;
  initial waitCnt = 2'h0;
  // Slow answer so the sequencer has to hold its request
  always @(posedge mclk) waitCnt <= (detectReq | extReq) ? waitCnt + 2'h1 : 2'h0;
  assign detectDone = detectReq & (waitCnt == 2'h3);
  assign detectOutcome = detectDone ? sigCode : ~sigCode;
  assign classResult = classDrive ? classCode : ~classCode;
  assign extDone = extReq & (waitCnt == 2'h3);
  assign extOk = extDone;
  assign extLevel = extDone ? levelWant : ~levelWant;
endmodule

// *** tb/ppdcc_top_tb_top.sv ***
// Purpose: Self-checking bench for the PSE sequencer with a device model
// Assumes: Class event shortened to CC cycles
// Notes: Each trial resets the block so new straps are latched
`timescale 1ns/1ps
module ppdcc_top_tb_top;
  import ppdcc_pkg::*;
  localparam int CC = 20;
  logic mclk, rst_n, resetPinN, midspanSelect, legacyEnable, twinSignatureEnable;
  logic cutFault, limFault, disconnect, detectReq, detectDone, classDrive, extReq;
  logic extDone, extOk, portPower, currentDouble, cutoffDisable, midspanTiming;
  logic [2:0] levelSelect, detectOutcome, classResult, extLevel, sigCode, classCode, levelWant;
  logic [3:0] allocLevel, thresholdSelect, s_axi_wstrb;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sawExt, sawClass;
  int nFail, nTests, classLen, lastLen;

  ppdcc_top #(.CLASS_CYCLES_P(CC)) DUT (
    .mclk, .rst_n, .resetPinN, .levelSelect, .midspanSelect, .legacyEnable,
    .twinSignatureEnable, .detectReq, .detectDone, .detectOutcome, .classDrive,
    .classResult, .extReq, .extDone, .extOk, .extLevel, .portPower, .cutFault,
    .limFault, .disconnect, .allocLevel, .thresholdSelect, .currentDouble,
    .cutoffDisable, .midspanTiming, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ppdcc_pd_model PD (.mclk, .detectReq, .classDrive, .extReq, .sigCode, .classCode,
    .levelWant, .detectDone, .detectOutcome, .classResult, .extDone, .extOk, .extLevel);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Class event length and extra events, measured at the ports
  always @(posedge mclk) begin
    if (classDrive === 1'b1) classLen <= classLen + 1;
    else if (classLen != 0) begin
      lastLen <= classLen;
      classLen <= 0;
    end
    if (rst_n === 1'b0) begin
      sawExt <= 1'b0;
      sawClass <= 1'b0;
    end else begin
      if (classDrive === 1'b1) sawClass <= 1'b1;
      if (extReq === 1'b1) sawExt <= 1'b1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic testDone();
    $display("checks %0d failures %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic axiWrite(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [4:0] a);
    @(posedge mclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata; rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic waitPower();
    int k;
    k = 0;
    while (portPower !== 1'b1 && k < 150) begin
      @(negedge mclk);
      k++;
    end
    @(negedge mclk);
  endtask

  function automatic logic [3:0] expAlloc(input logic [2:0] lvl, cls, ext, input logic leg);
    if (lvl == 3'h6) return 4'h9;
    if (cls != 3'h4) return (leg || cls == 3'h0 || cls == 3'h3) ? 4'h3 : {2'h0, cls[1:0]};
    if (lvl == 3'h0) return 4'h3;
    if (ext <= lvl) return {1'b0, ext} + 4'h3;
    return (lvl == 3'h1) ? 4'h4 : 4'h0;
  endfunction

  task automatic trial(input logic [2:0] lvl, sig, cls, ext, input logic leg, twin);
    logic ok;
    logic [3:0] al;
    ok = sig == DET_GOOD || (twin && sig == DET_SIG_LOW) || (leg && (sig == DET_CAP_HIGH
      || sig == DET_SIG_LOW || sig == DET_SIG_HIGH));
    al = expAlloc(lvl, cls, ext, leg);
    @(posedge mclk);
    levelSelect <= lvl; legacyEnable <= leg; twinSignatureEnable <= twin;
    midspanSelect <= lvl[0]; sigCode <= sig; classCode <= cls; levelWant <= ext;
    rst_n <= 1'b0;
    @(negedge mclk);
    check("reset off", portPower, 0);
    @(posedge mclk);
    rst_n <= 1'b1;
    waitPower();
    check("power", portPower, ok && al != 0);
    check("midspan", midspanTiming, lvl[0]);
    check("extend", sawExt, ok && cls == 3'h4 && lvl != 3'h0 && lvl != 3'h6);
    if (ok) check("class time", lastLen, CC);
    else check("detect again", {sawClass, detectReq}, 2'h1);
    if (portPower === 1'b1) begin
      check("alloc", allocLevel, al);
      check("threshold", thresholdSelect, al);
      check("double", currentDouble, twin && sig == DET_SIG_LOW);
      check("no cutoff", cutoffDisable, lvl == 3'h6);
      @(posedge mclk);
      {cutFault, limFault, disconnect} <= 3'h1 << (sig % 3);
      @(posedge mclk);
      {cutFault, limFault, disconnect} <= 3'h0;
      @(negedge mclk);
      check("power off", portPower, 0);
    end
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    nFail++;
    testDone();
  end

  initial begin
    nFail = 0; nTests = 0; classLen = 0; lastLen = 0;
    rst_n = 1'b0; resetPinN = 1'b1; levelSelect = 3'h0; midspanSelect = 1'b0;
    legacyEnable = 1'b0; twinSignatureEnable = 1'b0; cutFault = 1'b0; limFault = 1'b0;
    disconnect = 1'b0; sigCode = 3'h4; classCode = 3'h0; levelWant = 3'h1;
    s_axi_awaddr = 5'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0; s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 5'h00; s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    nTests = $urandom(16532) & 0;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 7; i++) trial(3'(i), DET_GOOD, 3'h4, 3'h5, 1'b0, 1'b0);
    waitPower();
    @(posedge mclk);
    {levelSelect, midspanSelect, legacyEnable, twinSignatureEnable} <= 6'h3f;
    resetPinN <= 1'b0;
    repeat (1000) @(posedge mclk);
    resetPinN <= 1'b1;
    @(negedge mclk);
    check("short pin low", portPower, 1);
    axiRead(OFS_CONFIG);
    check("config kept", rd, 32'h46);
    resetPinN <= 1'b0;
    repeat (1130) @(posedge mclk);
    check("pin reset", portPower, 0);
    levelSelect <= 3'h7;
    resetPinN <= 1'b1;
    repeat (4) @(posedge mclk);
    axiRead(OFS_CONFIG);
    check("config new", rd, 32'h78);
    waitPower();
    axiWrite(OFS_CTRL, 32'h0);
    axiRead(OFS_STATUS);
    check("idle", {rsp, rd[3:0]}, 6'h0a);
    axiRead(5'h10);
    check("unmapped", {rsp, rd}, {RESP_SLVERR, 32'h0});
    axiRead(OFS_EVENTS);
    check("fault event", rd, 32'h2);
    axiWrite(OFS_EVENTS, 32'hf);
    check("write resp", rsp, RESP_OKAY);
    axiRead(OFS_EVENTS);
    check("event clear", rd, 32'h0);
    for (int i = 0; i < 8; i++) trial(3'h3, 3'(i), 3'h1, 3'h1, i[2], i[1]);
    for (int i = 0; i < 40; i++) trial(3'($urandom_range(6)), 3'($urandom_range(7)),
      3'($urandom_range(4)), 3'($urandom_range(5, 1)), 1'($urandom), 1'($urandom));
    testDone();
  end
endmodule
